// file: include/sphb_pkg.sv
// shared constants and types for the switch packet descriptor builder
package sphb_pkg;
  localparam int unsigned W1_SRC_HI = 31;
  localparam int unsigned W1_SRC_LO = 27;
  localparam int unsigned W1_DST_HI = 26;
  localparam int unsigned W2_PID_LO = 26;
  localparam int unsigned W2_ERR_BIT = 25;
  localparam int unsigned W2_CRCPAD_BIT = 24;
  localparam int unsigned W2_RUNT_BIT = 23;
  localparam int unsigned W2_FRAME_BIT = 21;
  localparam int unsigned W2_FCS_BIT = 20;
  localparam int unsigned W2_BCAST_BIT = 19;
  localparam int unsigned W2_MCAST_BIT = 18;
  localparam int unsigned W2_OVF_BIT = 16;
  localparam int unsigned W2_WCNT_LO = 2;
  localparam int unsigned NPORTS = 27;
  localparam int unsigned MIN_BYTES = 64;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [4:0] CPU_PORT = 5'h1A;
  localparam logic [1:0] LAST_FULL = 2'h0;

  typedef struct packed {
    logic [4:0] src_port;
    logic [26:0] dst_map;
  } sphb_word1_t;

  typedef struct packed {
    logic [5:0] pkt_id;
    logic err_any;
    logic crc_pad;
    logic runt;
    logic rsv22;
    logic frame_err;
    logic fcs_err;
    logic bcast;
    logic mcast;
    logic rsv17;
    logic ovf_err;
    logic [3:0] rsv15_12;
    logic [9:0] word_cnt;
    logic [1:0] last_bytes;
  } sphb_word2_t;

  // transmit queue entry: packet start address plus selected descriptor fields
  typedef struct packed {
    logic [23:0] start_addr;
    logic [5:0] pkt_id;
    logic [4:0] src_port;
    logic crc_pad;
    logic [9:0] word_cnt;
    logic [1:0] last_bytes;
  } sphb_txq_t;

  localparam int unsigned TXQ_W = $bits(sphb_txq_t);
endpackage

// file: src/sphb_fifo.sv
// parameterised valid/ready fifo for transmit queue entries
`timescale 1ns/100ps
`default_nettype none
module sphb_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sphb_fifo
`default_nettype wire

// file: src/sphb_top.sv
// packet descriptor builder (receive) and snooper (transmit) for one port
// Operation
// - receive builds two-word 32-bit descriptor per packet
// - descriptor sent last, after all data words
// - descriptor stored at packet head in buffer
// - every port snoops descriptor for own bit
// - error flags decide filter or forward
// - forward queues fields plus start address
// - descriptor bits never reach the network
// - word1 bits 31:27 source port number
// - word1 bits 26:0 destination port bitmap
// - word2 bits 31:26 unique packet identifier
// - identifier plus address tracks the packet
// - bit 23 runt under 64 bytes
// - bit 21 framing error, partial byte
// - bit 20 frame check sequence error
// - bit 16 receive fifo overflow seen
// - bit 24 host CRC append and pad
// - bits 19/18 broadcast/multicast, else unicast
// - bits 11:2 buffer word count
// - bits 1:0 bytes in last word
`timescale 1ns/100ps
`default_nettype none
module sphb_top
  import sphb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] my_port,
  // receive side: packet stream from receive fifo
  input wire logic rx_start,
  input wire logic [23:0] rx_start_addr,
  input wire logic rx_word_valid,
  input wire logic [31:0] rx_word,
  input wire logic rx_end,
  input wire logic [1:0] rx_last_bytes,
  input wire logic rx_dribble,
  input wire logic rx_fcs_bad,
  input wire logic rx_fifo_ovf,
  input wire logic rx_bcast,
  input wire logic rx_mcast,
  input wire logic rx_crc_pad,
  input wire logic [26:0] rx_dst_map,
  input wire logic [5:0] rx_pkt_id,
  // switching bus, driven by this port
  output logic bus_valid,
  output logic [31:0] bus_data,
  output logic bus_hdr,
  output logic [23:0] hdr_buf_addr,
  // switching bus, snooped from any port
  input wire logic snp_hdr1,
  input wire logic snp_hdr2,
  input wire logic [31:0] snp_data,
  input wire logic [23:0] snp_start_addr,
  // transmit queue readout
  output logic txq_valid,
  input wire logic txq_ready,
  output logic [47:0] txq_entry,
  output logic filt_pulse,
  output logic txq_full
);
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_HDR1, ST_HDR2} sphb_state_t;
  sphb_state_t st_q, st_d;

  // receive accounting
  logic [9:0] wcnt_q;
  logic [6:0] bytes_q;
  logic ovf_q;
  logic frame_q;
  logic fcs_q;
  logic bc_q;
  logic mc_q;
  logic pad_q;
  logic [26:0] dst_q;
  logic [5:0] pid_q;
  logic [1:0] lastb_q;
  logic [23:0] addr_q;

  wire counting = (st_q == ST_DATA) && rx_word_valid;
  wire [9:0] wcnt_nx = counting ? wcnt_q + 10'h001 : wcnt_q;
  // bytes saturate at the runt limit; only the under-64 test is needed
  wire last_part = rx_end && rx_last_bytes != LAST_FULL;
  wire [6:0] bytes_add = last_part ? {5'h00, rx_last_bytes} : 7'h04;
  wire [6:0] bytes_nx = (bytes_q >= 7'(MIN_BYTES)) ? bytes_q : bytes_q + bytes_add;
  wire runt = (bytes_q < 7'(MIN_BYTES));

  sphb_word1_t w1;
  sphb_word2_t w2;
  assign w1.src_port = my_port;
  assign w1.dst_map = dst_q;
  assign w2.pkt_id = pid_q;
  assign w2.err_any = runt | frame_q | fcs_q | ovf_q;
  assign w2.crc_pad = (my_port == CPU_PORT) && pad_q;
  assign w2.runt = runt;
  assign w2.frame_err = frame_q;
  assign w2.fcs_err = fcs_q;
  assign w2.bcast = bc_q;
  assign w2.mcast = mc_q && !bc_q;
  assign w2.ovf_err = ovf_q;
  assign w2.word_cnt = wcnt_q;
  assign w2.last_bytes = lastb_q;
  assign w2.rsv22 = 1'b0;
  assign w2.rsv17 = 1'b0;
  assign w2.rsv15_12 = 4'h0;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (rx_start) st_d = ST_DATA;
      ST_DATA: if (rx_end) st_d = ST_HDR1;
      ST_HDR1: st_d = ST_HDR2;
      ST_HDR2: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wcnt_q <= '0;
      bytes_q <= '0;
      ovf_q <= 1'b0;
      frame_q <= 1'b0;
      fcs_q <= 1'b0;
      bc_q <= 1'b0;
      mc_q <= 1'b0;
      pad_q <= 1'b0;
      dst_q <= '0;
      pid_q <= '0;
      lastb_q <= LAST_FULL;
      addr_q <= '0;
    end else if (st_q == ST_IDLE && rx_start) begin
      wcnt_q <= '0;
      bytes_q <= '0;
      ovf_q <= rx_fifo_ovf;
      frame_q <= 1'b0;
      fcs_q <= 1'b0;
      bc_q <= 1'b0;
      mc_q <= 1'b0;
      pad_q <= 1'b0;
      dst_q <= '0;
      pid_q <= rx_pkt_id;
      lastb_q <= LAST_FULL;
      addr_q <= rx_start_addr;
    end else if (st_q == ST_DATA) begin
      wcnt_q <= wcnt_nx;
      if (counting) begin
        bytes_q <= bytes_nx;
      end
      ovf_q <= ovf_q | rx_fifo_ovf;
      if (rx_end) begin
        frame_q <= rx_dribble;
        fcs_q <= rx_fcs_bad;
        bc_q <= rx_bcast;
        mc_q <= rx_mcast;
        pad_q <= rx_crc_pad;
        dst_q <= rx_dst_map;
        lastb_q <= rx_last_bytes;
      end
    end
  end

  // bus output: data then header words; header flagged for buffer head write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_valid <= 1'b0;
      bus_data <= '0;
      bus_hdr <= 1'b0;
      hdr_buf_addr <= '0;
    end else begin
      bus_valid <= counting || st_q == ST_HDR1 || st_q == ST_HDR2;
      bus_hdr <= (st_q == ST_HDR1) || (st_q == ST_HDR2);
      hdr_buf_addr <= addr_q;
      unique case (st_q)
        ST_HDR1: bus_data <= w1;
        ST_HDR2: bus_data <= w2;
        default: bus_data <= counting ? rx_word : 32'h0;
      endcase
    end
  end

  // snoop side: word 1 is held one cycle until word 2 arrives
  // a word 2 seen without its word 1 is ignored
  sphb_word1_t s1_q;
  logic s1_seen_q;
  sphb_word2_t s2;
  assign s2 = snp_data;
  wire mine = s1_q.dst_map[my_port];
  wire bad = s2.runt | s2.frame_err | s2.fcs_err | s2.ovf_err | s2.err_any;
  wire fwd = snp_hdr2 && s1_seen_q && mine && !bad;
  sphb_txq_t ent;
  assign ent.start_addr = snp_start_addr;
  assign ent.pkt_id = s2.pkt_id;
  assign ent.src_port = s1_q.src_port;
  assign ent.crc_pad = s2.crc_pad;
  assign ent.word_cnt = s2.word_cnt;
  assign ent.last_bytes = s2.last_bytes;

  logic q_ready;
  logic q_valid;
  logic [TXQ_W-1:0] q_data;
  // pop only when the output register takes the entry
  // else an entry would be popped and lost while a stalled reader holds the output
  logic txq_valid_q_hold;
  assign txq_valid_q_hold = txq_valid && !txq_ready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s1_seen_q <= 1'b0;
      filt_pulse <= 1'b0;
      txq_full <= 1'b0;
    end else begin
      if (snp_hdr1) begin
        s1_q <= snp_data;
      end
      s1_seen_q <= snp_hdr1;
      filt_pulse <= snp_hdr2 && s1_seen_q && mine && bad;
      txq_full <= !q_ready;
    end
  end

  // fifo holds only queue entries, never descriptor words for the network
  sphb_fifo #(.WIDTH(TXQ_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk(clk),
    .nrst(nrst),
    .in_valid(fwd),
    .in_ready(q_ready),
    .in_data(ent),
    .out_valid(q_valid),
    .out_ready(!txq_valid_q_hold),
    .out_data(q_data)
  );

  // registered output stage; entry carries no raw descriptor word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txq_valid <= 1'b0;
      txq_entry <= '0;
    end else if (!txq_valid || txq_ready) begin
      txq_valid <= q_valid;
      txq_entry <= q_data;
    end
  end

  // header words follow the last data word; reserved bits stay clear
  sequence s_hdr_first;
    bus_hdr && bus_data[W1_SRC_HI:W1_SRC_LO] == my_port;
  endsequence
  sequence s_hdr_second;
    bus_hdr && bus_data[22] == 1'b0 && bus_data[17] == 1'b0 && bus_data[15:12] == 4'h0;
  endsequence

  a_hdr_order: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_DATA && rx_end) |=> ##1 s_hdr_first ##1 s_hdr_second)
    else $error("header order wrong");

  a_two_words: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_HDR2) |=> ##1 !bus_hdr)
    else $error("header longer than two words");

  a_err_sum: assert property (@(posedge clk) disable iff (!nrst)
    (bus_hdr && $past(st_q) == ST_HDR2) |->
    bus_data[25] == (bus_data[23] | bus_data[21] | bus_data[20] | bus_data[16]))
    else $error("error summary wrong");

  a_cast_excl: assert property (@(posedge clk) disable iff (!nrst)
    (bus_hdr && $past(st_q) == ST_HDR2) |-> !(bus_data[19] && bus_data[18]))
    else $error("broadcast and multicast both set");

  a_wcnt_hdr: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_HDR2) |=> bus_data[11:2] == $past(wcnt_q))
    else $error("word count");

  a_data_echo: assert property (@(posedge clk) disable iff (!nrst)
    counting |=> (bus_valid && !bus_hdr && bus_data == $past(rx_word)))
    else $error("data word not passed on");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_IDLE) |=> !bus_valid)
    else $error("bus driven while idle");

  // snoop forwarding and queue handshake
  a_fwd_filter: assert property (@(posedge clk) disable iff (!nrst)
    (snp_hdr2 && s1_seen_q && mine && bad) |=> filt_pulse)
    else $error("no filter");

  a_fwd_push: assert property (@(posedge clk) disable iff (!nrst)
    (fwd && q_ready) |=> q_valid)
    else $error("forward not queued");

  a_drop_full: assert property (@(posedge clk) disable iff (!nrst)
    (fwd && !q_ready) |=> txq_full)
    else $error("drop without full flag");

  a_txq_hold: assert property (@(posedge clk) disable iff (!nrst)
    (txq_valid && !txq_ready) |=> (txq_valid && $stable(txq_entry)))
    else $error("queue entry not held");
endmodule // sphb_top
`default_nettype wire

// file: tb/sphb_bus_model.sv
// neighbour port on the switching bus: sends descriptors, drains the tx queue
`timescale 1ns/100ps
`default_nettype none
module sphb_bus_model (
  input wire logic clk,
  input wire logic hold,
  input wire logic slow,
  output logic snp_hdr1,
  output logic snp_hdr2,
  output logic [31:0] snp_data,
  output logic [23:0] snp_start_addr,
  output logic txq_ready
);
  logic [1:0] cyc_q = 2'h0;
  initial begin
    {snp_hdr1, snp_hdr2} = 2'h0;
    snp_data = 32'h0;
    snp_start_addr = 24'h0;
  end
  always @(posedge clk) cyc_q <= cyc_q + 2'h1;
  // slow reader takes one entry every fourth cycle, so the queue backs up
  assign txq_ready = !hold && (!slow || cyc_q == 2'h0);
  task automatic send(input logic [31:0] w1, input logic [31:0] w2, input logic [23:0] a);
    @(posedge clk) #1;
    snp_hdr1 = 1'b1;
    snp_data = w1;
    @(posedge clk) #1;
    snp_hdr1 = 1'b0;
    snp_hdr2 = 1'b1;
    snp_data = w2;
    snp_start_addr = a;
    @(posedge clk) #1;
    snp_hdr2 = 1'b0;
    // released bus must not look like a stale descriptor
    snp_data = ~w2;
    snp_start_addr = ~a;
  endtask
endmodule // sphb_bus_model
`default_nettype wire

// file: tb/tb_switch_packet_header_builder.sv
// bench: receive descriptors, snooped forwarding and tx queue fill
`timescale 1ns/100ps
`default_nettype none
module tb_switch_packet_header_builder
  import sphb_pkg::*;
;
  logic clk, nrst, rx_start, rx_word_valid, rx_end, rx_dribble, rx_fcs_bad, rx_fifo_ovf;
  logic rx_bcast, rx_mcast, rx_crc_pad, bus_valid, bus_hdr, txq_valid, txq_ready;
  logic filt_pulse, txq_full, hold, slow, snp_hdr1, snp_hdr2;
  logic [4:0] my_port;
  logic [23:0] rx_start_addr, hdr_buf_addr, snp_start_addr;
  logic [31:0] rx_word, bus_data, snp_data, seed;
  logic [1:0] rx_last_bytes;
  logic [26:0] rx_dst_map;
  logic [5:0] rx_pkt_id;
  logic [47:0] txq_entry;
  logic [56:0] be;
  logic [56:0] bus_q[$];
  logic [47:0] txq_q[$];
  int err_count, num_checks, filt_exp, filt_seen, cyc;
  int eb[5] = '{25, 23, 21, 20, 16};

  sphb_top dut (.clk, .nrst, .my_port, .rx_start, .rx_start_addr, .rx_word_valid, .rx_word,
    .rx_end, .rx_last_bytes, .rx_dribble, .rx_fcs_bad, .rx_fifo_ovf, .rx_bcast, .rx_mcast,
    .rx_crc_pad, .rx_dst_map, .rx_pkt_id, .bus_valid, .bus_data, .bus_hdr, .hdr_buf_addr,
    .snp_hdr1, .snp_hdr2, .snp_data, .snp_start_addr, .txq_valid, .txq_ready, .txq_entry,
    .filt_pulse, .txq_full);
  sphb_bus_model bm (.clk, .hold, .slow, .snp_hdr1, .snp_hdr2, .snp_data, .snp_start_addr,
    .txq_ready);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // e: dribble fcs ovf bcast mcast crc_pad
  task automatic rx_pkt(input int n, input logic [1:0] lb, input logic [5:0] e);
    logic [31:0] w;
    logic [23:0] a;
    logic runt;
    int b;
    w = xs();
    a = w[23:0];
    @(posedge clk) #1;
    rx_start = 1'b1;
    rx_start_addr = a;
    rx_pkt_id = w[31:26];
    {rx_dribble, rx_fcs_bad, rx_bcast, rx_mcast, rx_crc_pad} = {e[5:4], e[2:0]};
    rx_last_bytes = lb;
    w = xs();
    rx_dst_map = w[26:0];
    for (int i = 0; i < n; i++) begin
      @(posedge clk) #1;
      // a second start mid-packet must be ignored
      rx_start = (i == 1);
      if (i == 1) rx_start_addr = ~a;
      rx_word_valid = 1'b1;
      rx_word = xs();
      rx_end = (i == n - 1);
      rx_fifo_ovf = e[3] && i == n / 2;
      bus_q.push_back({a, 1'b0, rx_word});
    end
    @(posedge clk) #1;
    {rx_start, rx_word_valid, rx_end, rx_fifo_ovf} = 4'h0;
    rx_word = ~rx_word;
    b = (n - 1) * 4 + (lb == 2'h0 ? 4 : int'(lb));
    runt = b < MIN_BYTES;
    bus_q.push_back({a, 1'b1, my_port, rx_dst_map});
    bus_q.push_back({a, 1'b1, rx_pkt_id, |{runt, e[5:3]}, e[0] && my_port == CPU_PORT, runt,
      1'b0, e[5:4], e[2], e[1] & ~e[2], 1'b0, e[3], 4'h0, 10'(n), lb});
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic snoop(input logic mine, input logic [31:0] w2);
    logic [31:0] w1;
    logic [23:0] a;
    logic bad;
    w1 = xs();
    a = w1[23:0];
    w1 = xs();
    w1[my_port] = mine;
    bad = |(w2 & 32'h02B1_0000);
    if (mine && bad) filt_exp++;
    // fifo plus output register hold nine; a full queue drops the forward
    if (mine && !bad && txq_q.size() < FIFO_DEPTH + 1)
      txq_q.push_back({a, w2[31:26], w1[31:27], w2[24], w2[11:0]});
    bm.send(w1, w2, a);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic drain();
    repeat (300) if (txq_q.size() != 0) @(posedge clk);
    #1;
    cmp("txq left", 64'h0, 64'(txq_q.size()));
  endtask

  always @(negedge clk) begin
    if (nrst && bus_valid) begin
      if (bus_q.size() == 0) cmp("bus extra", 64'h0, 64'h1);
      else begin
        be = bus_q.pop_front();
        cmp("bus word", {31'h0, be[32:0]}, {31'h0, bus_hdr, bus_data});
        if (be[32]) cmp("hdr addr", {40'h0, be[56:33]}, {40'h0, hdr_buf_addr});
      end
    end
    if (nrst && txq_valid && txq_ready) begin
      if (txq_q.size() == 0) cmp("txq extra", 64'h0, 64'h1);
      else cmp("txq entry", {16'h0, txq_q.pop_front()}, {16'h0, txq_entry});
    end
    if (nrst && filt_pulse) filt_seen++;
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    {nrst, rx_start, rx_word_valid, rx_end, rx_dribble, rx_fcs_bad, rx_fifo_ovf} = 7'h0;
    {rx_bcast, rx_mcast, rx_crc_pad, hold, slow} = 5'h0;
    {rx_start_addr, rx_word, rx_last_bytes, rx_dst_map, rx_pkt_id} = 91'h0;
    my_port = 5'h05;
    seed = 32'h11;
    repeat (16) @(posedge clk);
    cmp("reset outs", 64'h0, {60'h0, bus_valid, txq_valid, filt_pulse, txq_full});
    #1 nrst = 1'b1;
    rx_pkt(16, 2'h0, 6'h00);
    rx_pkt(16, 2'h3, 6'h00);
    rx_pkt(1, 2'h1, 6'h00);
    for (int k = 0; k < 6; k++) rx_pkt(20, 2'h2, 6'h01 << k);
    rx_pkt(17, 2'h1, 6'h06);
    my_port = CPU_PORT;
    rx_pkt(18, 2'h0, 6'h01);
    my_port = 5'h05;
    $display("test receive done");
    slow = 1'b1;
    for (int k = 0; k < 12; k++) snoop(k[0], xs() & (k < 6 ? 32'hFD4E_FFFF : '1));
    foreach (eb[j]) snoop(1'b1, 32'h1 << eb[j]);
    drain();
    $display("test snoop done");
    hold = 1'b1;
    slow = 1'b0;
    repeat (10) snoop(1'b1, xs() & 32'hFD4E_FFFF);
    cmp("txq full", 64'h1, {63'h0, txq_full});
    hold = 1'b0;
    drain();
    cmp("filtered", 64'(filt_exp), 64'(filt_seen));
    cmp("bus left", 64'h0, 64'(bus_q.size()));
    $display("test queue fill done");
    tally_and_finish();
  end
endmodule // tb_switch_packet_header_builder
`default_nettype wire
